/* File: hdl/tmc_pkg.sv */
// Constants shared by the TAP master configuration block.
package tmc_pkg;
  // Register addresses on the three host address pins.
  localparam logic [2:0] CFG_A_ADDR = 3'h0;
  localparam logic [2:0] CFG_B_ADDR = 3'h1;
  // Reset values and writable-bit masks; reserved bits read as zero.
  localparam logic [7:0] CFG_A_RESET = 8'h00;
  localparam logic [7:0] CFG_B_RESET = 8'h80;
  localparam logic [7:0] CFG_A_MASK = 8'h3F;
  localparam logic [7:0] CFG_B_MASK = 8'hEF;
  // Field positions in the control register.
  localparam int SOFT_DISABLE_BIT = 5;
  localparam int LOOPBACK_LSB = 3;
  localparam int MODE_LSB = 0;
  // Field positions in the timing register.
  localparam int DIVISOR_LSB = 5;
  localparam int RETIMING_LSB = 0;
  // Loopback selections.
  localparam logic [1:0] LOOP_NONE = 2'h0;
  localparam logic [1:0] LOOP_TMS = 2'h1;
  localparam logic [1:0] LOOP_TDO = 2'h2;
  // Operating modes.
  localparam logic [2:0] MODE_FREE = 3'h0;
  localparam logic [2:0] MODE_GATED = 3'h1;
  localparam logic [2:0] MODE_DISCRETE = 3'h2;
  // Host pin sync vector layout and its idle value (strobe high).
  localparam int HSYNC_W = 13;
  localparam int HS_STRB = 0;
  localparam int HS_RW = 1;
  localparam int HS_ADDR = 2;
  localparam int HS_DATA = 5;
  localparam logic [12:0] HSYNC_IDLE = 13'h0003;
  // Link pin sync vector: bit 0 TDI, bit 1 active-low output enable.
  localparam int LS_TDI = 0;
  localparam int LS_OE_N = 1;
  localparam logic [1:0] LSYNC_IDLE = 2'h0;
endpackage : tmc_pkg

/* File: hdl/tmc_top.sv */
// TAP master configuration registers, TCK generation and TDI sampling.
`timescale 1ns/1ps
// What this block does
// [RL1] Software disable bit floats the four TAP outputs.
// [RL2] Loopback 00 feeds TDI buffer from pin.
// [RL3] Loopback 01 feeds TDI buffer from TMS generator.
// [RL4] Loopback 10 feeds TDI buffer from TDO buffer.
// [RL5] Any loopback holds TMS and TDO high.
// [RL6] Mode 000 runs TCK continuously, autonomous outputs.
// [RL7] Free mode buffer stall parks target in Pause.
// [RL8] Mode 001 pulses TCK only when needed.
// [RL9] Gated mode buffer stall stops TCK in Shift.
// [RL10] Mode 010 drives outputs from discrete register bits.
// [RL11] TCK equals reference clock over two-power divisor. Divisor exponent 0 still divides by two, the same as exponent 1.
// [RL12] Every reset restores divide-by-sixteen.
// [RL13] Retiming delay postpones TDI sampling after Shift.
// [RL14] Host never writes reserved field values.
// [RL15] Reads always allowed; writes refused while busy.
// [RL16] Hardware enable pin inactive also floats outputs.
module tmc_top (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic REFERENCE_CLOCK_IN,
  input wire logic STRB_N_IN,
  input wire logic RW_IN,
  input wire logic [2:0] ADDR_IN,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE_OUT,
  output logic RDY_OUT,
  input wire logic SOFT_RESET_IN,
  input wire logic CMD_BUSY_IN,
  input wire logic TDI_IN,
  input wire logic HW_OUTPUT_ENABLE_PIN_N_IN,
  input wire logic SCAN_ACTIVE_IN,
  input wire logic TDI_FULL_IN,
  input wire logic TDO_EMPTY_IN,
  input wire logic TCK_NEED_IN,
  input wire logic SHIFT_STATE_IN,
  input wire logic GEN_TMS_IN,
  input wire logic TDO_SERIAL_IN,
  input wire logic CMD_TRST_N_IN,
  input wire logic DISC_NTRST_IN,
  input wire logic DISC_TMS_IN,
  input wire logic DISC_TDO_IN,
  output logic TCK_OUT,
  output logic TMS_OUT,
  output logic TDO_OUT,
  output logic TRST_N_OUT,
  output logic TAP_OE_OUT,
  output logic TDI_BIT_OUT,
  output logic TDI_BIT_VALID_OUT,
  output logic PAUSE_REQ_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // State types, one per clock domain.

  typedef struct packed {
    logic [12:0] s1;
    logic [12:0] s2;
    logic [12:0] s3;
    logic [12:0] f;
    logic [2:0] addr;
    logic rw;
    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
    logic req;
    logic resend;
    logic ack_s1;
    logic ack_s2;
    logic [7:0] dout;
    logic doe;
    logic rdy;
  } tmc_host_type;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic ack;
    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] f;
    logic [6:0] cnt;
    logic tck;
    logic tms;
    logic tdo;
    logic trst_n;
    logic oe;
    logic tdi_bit;
    logic tdi_valid;
    logic pause_req;
    logic in_shift;
    logic [3:0] dly;
  } tmc_link_type;

  tmc_host_type host;
  tmc_host_type next_host;
  tmc_link_type link;
  tmc_link_type next_link;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Glitch filter: a bit changes once the second and third stages agree.
  function automatic logic tmc_filter(input logic s2, input logic s3,
                                      input logic old);
    tmc_filter = (s2 == s3) ? s2 : old;
  endfunction : tmc_filter

  // Last count of a TCK half period for a divisor exponent.
  function automatic logic [6:0] tmc_half_last(input logic [2:0] e);
    if (e == 3'h0) begin
      tmc_half_last = 7'h00;
    end else begin
      tmc_half_last = (7'h01 << (e - 3'h1)) - 7'h01;
    end
  endfunction : tmc_half_last

  ////////////////////////////////////////////////////////////////////////////
  // Host side: strobe interface and the two configuration registers.

  logic h_fall;
  logic h_rise;
  logic h_ours;
  logic h_blocked;

  // Next-state logic of the host side.
  always_comb begin
    next_host = host;
    // Pins pass three flip-flops; the first feeds only the second.
    next_host.s1 = {DATA_IN, ADDR_IN, RW_IN, STRB_N_IN};
    next_host.s2 = host.s1;
    next_host.s3 = host.s2;
    for (int i = 0; i < tmc_pkg::HSYNC_W; i++) begin
      next_host.f[i] = tmc_filter(host.s2[i], host.s3[i], host.f[i]);
    end
    h_fall = host.f[tmc_pkg::HS_STRB] && !next_host.f[tmc_pkg::HS_STRB];
    h_rise = !host.f[tmc_pkg::HS_STRB] && next_host.f[tmc_pkg::HS_STRB];
    // Address and direction are taken on the strobe's falling edge.
    if (h_fall) begin
      next_host.addr = next_host.f[tmc_pkg::HS_ADDR +: 3];
      next_host.rw = next_host.f[tmc_pkg::HS_RW];
    end
    h_ours = (next_host.addr == tmc_pkg::CFG_A_ADDR) ||
             (next_host.addr == tmc_pkg::CFG_B_ADDR);
    // A write waits for the command and for the previous crossing.
    // Holding writes off also keeps the words that cross standing still.
    h_blocked = CMD_BUSY_IN || (host.req != host.ack_s2);  // [RL15]
    // Acknowledge from the link side, two flip-flops.
    next_host.ack_s1 = link.ack;
    next_host.ack_s2 = host.ack_s1;
    // Data is taken on the rising edge; a blocked write is dropped.
    if (h_rise && !next_host.rw && h_ours && !h_blocked) begin  // [RL15]
      if (next_host.addr == tmc_pkg::CFG_A_ADDR) begin
        next_host.cfg_a = next_host.f[tmc_pkg::HS_DATA +: 8] &
                          tmc_pkg::CFG_A_MASK;
      end else begin
        next_host.cfg_b = next_host.f[tmc_pkg::HS_DATA +: 8] &
                          tmc_pkg::CFG_B_MASK;
      end
      next_host.req = !host.req;
    end
    // Resend a soft reset that landed during a crossing. The link side may
    // have caught the older words; a second toggle makes it copy the reset
    // values once they stand still.
    if (host.resend && (host.req == host.ack_s2)) begin
      next_host.resend = 1'b0;
      next_host.req = !host.req;
    end
    // Software reset restores both registers, divisor to sixteen.
    if (SOFT_RESET_IN) begin
      next_host.cfg_a = tmc_pkg::CFG_A_RESET;
      next_host.cfg_b = tmc_pkg::CFG_B_RESET;  // [RL12]
      if (host.req == host.ack_s2) begin
        next_host.req = !host.req;
      end else begin
        next_host.resend = 1'b1;
      end
    end
    // Reads are served at any time while the strobe is low.
    next_host.doe = !next_host.f[tmc_pkg::HS_STRB] && next_host.rw &&
                    h_ours;  // [RL15]
    next_host.dout = (next_host.addr == tmc_pkg::CFG_A_ADDR) ?
                     host.cfg_a : host.cfg_b;
    next_host.rdy = !(!next_host.f[tmc_pkg::HS_STRB] && !next_host.rw &&
                      h_ours && h_blocked);  // [RL15]
  end

  // Host side registers.
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      host <= '0;
      host.s1 <= tmc_pkg::HSYNC_IDLE;
      host.s2 <= tmc_pkg::HSYNC_IDLE;
      host.s3 <= tmc_pkg::HSYNC_IDLE;
      host.f <= tmc_pkg::HSYNC_IDLE;
      host.rw <= 1'b1;
      host.cfg_a <= tmc_pkg::CFG_A_RESET;
      host.cfg_b <= tmc_pkg::CFG_B_RESET;  // [RL12]
      host.rdy <= 1'b1;
    end else begin
      host <= next_host;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link side: TCK divider, mode handling, pin drive and TDI sampling.

  logic [1:0] l_loop;
  logic [2:0] l_mode;
  logic l_stall;
  logic l_tick;
  logic l_rise;
  logic l_src;

  // Next-state logic of the link side.
  always_comb begin
    next_link = link;
    // Configuration crosses by a toggle handshake; data is held stable.
    next_link.req_s1 = host.req;
    next_link.req_s2 = link.req_s1;
    if (link.req_s2 != link.ack) begin
      next_link.cfg_a = host.cfg_a;
      next_link.cfg_b = host.cfg_b;
      next_link.ack = link.req_s2;
    end
    l_loop = link.cfg_a[tmc_pkg::LOOPBACK_LSB +: 2];
    l_mode = link.cfg_a[tmc_pkg::MODE_LSB +: 3];
    // Pins pass three flip-flops; the first feeds only the second.
    next_link.s1 = {HW_OUTPUT_ENABLE_PIN_N_IN, TDI_IN};
    next_link.s2 = link.s1;
    next_link.s3 = link.s2;
    for (int i = 0; i < 2; i++) begin
      next_link.f[i] = tmc_filter(link.s2[i], link.s3[i], link.f[i]);
    end
    // Either disable source floats all four TAP outputs.
    next_link.oe = !link.cfg_a[tmc_pkg::SOFT_DISABLE_BIT] &&  // [RL1]
                   !link.f[tmc_pkg::LS_OE_N];  // [RL16]
    // Divider: one half period is 2^(exp-1) reference cycles, or one cycle for exp 0.
    l_tick = (link.cnt >= tmc_half_last(
              link.cfg_b[tmc_pkg::DIVISOR_LSB +: 3]));  // [RL11]
    next_link.cnt = l_tick ? 7'h00 : link.cnt + 7'h01;  // [RL11]
    l_stall = SCAN_ACTIVE_IN && (TDI_FULL_IN || TDO_EMPTY_IN);
    next_link.pause_req = 1'b0;
    l_rise = 1'b0;
    case (l_mode)
      tmc_pkg::MODE_FREE: begin
        // Clock never stops; a stall sends the target to Pause.
        l_rise = l_tick && !link.tck;  // [RL6]
        next_link.pause_req = l_stall;  // [RL7]
      end
      tmc_pkg::MODE_GATED: begin
        // A high phase always completes; a new pulse needs demand.
        l_rise = l_tick && !link.tck && TCK_NEED_IN;  // [RL8]
        if (l_stall) begin
          l_rise = 1'b0;  // [RL9]
        end
      end
      default: begin
        // Discrete and reserved modes leave TCK low.
        l_rise = 1'b0;  // [RL14]
      end
    endcase
    if (l_rise) begin
      next_link.tck = 1'b1;
    end else if (l_tick || (l_mode > tmc_pkg::MODE_GATED)) begin
      next_link.tck = 1'b0;  // [RL8]
    end
    // Pin values: loopback fixes TMS and TDO high.
    if (l_loop != tmc_pkg::LOOP_NONE) begin
      next_link.tms = 1'b1;  // [RL5]
      next_link.tdo = 1'b1;  // [RL5]
    end else if (l_mode == tmc_pkg::MODE_DISCRETE) begin
      next_link.tms = DISC_TMS_IN;  // [RL10]
      next_link.tdo = DISC_TDO_IN;  // [RL10]
    end else begin
      next_link.tms = GEN_TMS_IN;  // [RL6]
      next_link.tdo = TDO_SERIAL_IN;  // [RL6]
    end
    next_link.trst_n = (l_mode == tmc_pkg::MODE_DISCRETE) ?
                       DISC_NTRST_IN : CMD_TRST_N_IN;  // [RL10]
    // Source of the bit handed to the TDI buffer.
    case (l_loop)
      tmc_pkg::LOOP_NONE: l_src = link.f[tmc_pkg::LS_TDI];  // [RL2]
      tmc_pkg::LOOP_TMS: l_src = GEN_TMS_IN;  // [RL3]
      tmc_pkg::LOOP_TDO: l_src = TDO_SERIAL_IN;  // [RL4]
      default: l_src = link.f[tmc_pkg::LS_TDI];  // [RL14]
    endcase
    // Retiming: skip that many rising edges after entering Shift.
    next_link.in_shift = SHIFT_STATE_IN;
    next_link.tdi_valid = 1'b0;
    if (SHIFT_STATE_IN && !link.in_shift) begin
      next_link.dly = link.cfg_b[tmc_pkg::RETIMING_LSB +: 4];  // [RL13]
    end else if (l_rise && SHIFT_STATE_IN) begin
      if (link.dly != 4'h0) begin
        next_link.dly = link.dly - 4'h1;  // [RL13]
      end else begin
        next_link.tdi_bit = l_src;
        next_link.tdi_valid = 1'b1;  // [RL13]
      end
    end
  end

  // Link side registers.
  always_ff @(posedge REFERENCE_CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      link <= '0;
      link.cfg_a <= tmc_pkg::CFG_A_RESET;
      link.cfg_b <= tmc_pkg::CFG_B_RESET;  // [RL12]
      link.s1 <= tmc_pkg::LSYNC_IDLE;
      link.s2 <= tmc_pkg::LSYNC_IDLE;
      link.s3 <= tmc_pkg::LSYNC_IDLE;
      link.f <= tmc_pkg::LSYNC_IDLE;
      link.tms <= 1'b1;
      link.tdo <= 1'b1;
      link.trst_n <= 1'b1;
      link.oe <= 1'b1;
    end else begin
      link <= next_link;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop.

  assign DATA_OUT = host.dout;
  assign DATA_OE_OUT = host.doe;
  assign RDY_OUT = host.rdy;
  assign TCK_OUT = link.tck;
  assign TMS_OUT = link.tms;
  assign TDO_OUT = link.tdo;
  assign TRST_N_OUT = link.trst_n;
  assign TAP_OE_OUT = link.oe;  // [RL1]
  assign TDI_BIT_OUT = link.tdi_bit;
  assign TDI_BIT_VALID_OUT = link.tdi_valid;
  assign PAUSE_REQ_OUT = link.pause_req;

endmodule : tmc_top

/* File: tb/tmc_checker.sv */
// Port-level assertions for the TAP master configuration block.
`timescale 1ns/1ps
module tmc_checker (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic REFERENCE_CLOCK_IN,
  input wire logic STRB_N_IN,
  input wire logic RW_IN,
  input wire logic [2:0] ADDR_IN,
  input wire logic CMD_BUSY_IN,
  input wire logic HW_OUTPUT_ENABLE_PIN_N_IN,
  input wire logic SCAN_ACTIVE_IN,
  input wire logic TDI_FULL_IN,
  input wire logic TDO_EMPTY_IN,
  input wire logic DATA_OE_OUT,
  input wire logic RDY_OUT,
  input wire logic TCK_OUT,
  input wire logic TAP_OE_OUT,
  input wire logic TDI_BIT_VALID_OUT,
  input wire logic PAUSE_REQ_OUT
);
  property p_hw_float;
    @(posedge REFERENCE_CLOCK_IN) disable iff (RST_IN)
    HW_OUTPUT_ENABLE_PIN_N_IN [*6] |-> !TAP_OE_OUT;
  endproperty
  a_hw_float: assert property (p_hw_float)
    else $error("TAP outputs driven with enable pin off");
  property p_valid_rise;
    @(posedge REFERENCE_CLOCK_IN) disable iff (RST_IN)
    TDI_BIT_VALID_OUT |-> TCK_OUT && !$past(TCK_OUT);
  endproperty
  a_valid_rise: assert property (p_valid_rise)
    else $error("TDI bit outside a TCK rise");
  property p_pause;
    @(posedge REFERENCE_CLOCK_IN) disable iff (RST_IN)
    PAUSE_REQ_OUT |-> $past(SCAN_ACTIVE_IN && (TDI_FULL_IN || TDO_EMPTY_IN));
  endproperty
  a_pause: assert property (p_pause)
    else $error("pause asked without a stall");
  property p_reset_link;
    @(posedge REFERENCE_CLOCK_IN) disable iff (RST_IN)
    $fell(RST_IN) |-> TAP_OE_OUT && !TDI_BIT_VALID_OUT;
  endproperty
  a_reset_link: assert property (p_reset_link)
    else $error("bad TAP outputs leaving reset");
  property p_read_drive;
    @(posedge CLK_IN) disable iff (RST_IN)
    $rose(DATA_OE_OUT) |-> RW_IN && !STRB_N_IN && ADDR_IN < 3'h2;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("data bus driven outside a register read");
  property p_rdy_fall;
    @(posedge CLK_IN) disable iff (RST_IN)
    $fell(RDY_OUT) |-> !RW_IN && !STRB_N_IN && ADDR_IN < 3'h2;
  endproperty
  a_rdy_fall: assert property (p_rdy_fall)
    else $error("ready dropped outside a register write");
  property p_write_block;
    @(posedge CLK_IN) disable iff (RST_IN)
    (!STRB_N_IN && !RW_IN && ADDR_IN < 3'h2 && CMD_BUSY_IN) [*7] |-> !RDY_OUT;
  endproperty
  a_write_block: assert property (p_write_block)
    else $error("write while busy not held off");
  property p_oe_release;
    @(posedge CLK_IN) disable iff (RST_IN)
    STRB_N_IN [*8] |-> !DATA_OE_OUT;
  endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("data bus still driven after strobe");
  // Main scenarios worth seeing at least once.
  c_block: cover property (@(posedge CLK_IN) $fell(RDY_OUT));
  c_pause: cover property (@(posedge REFERENCE_CLOCK_IN) PAUSE_REQ_OUT);
  c_valid: cover property (@(posedge REFERENCE_CLOCK_IN) TDI_BIT_VALID_OUT);
endmodule : tmc_checker
bind tmc_top tmc_checker u_chk (.CLK_IN, .RST_IN, .REFERENCE_CLOCK_IN,
  .STRB_N_IN, .RW_IN, .ADDR_IN, .CMD_BUSY_IN, .HW_OUTPUT_ENABLE_PIN_N_IN,
  .SCAN_ACTIVE_IN, .TDI_FULL_IN, .TDO_EMPTY_IN, .DATA_OE_OUT, .RDY_OUT,
  .TCK_OUT, .TAP_OE_OUT, .TDI_BIT_VALID_OUT, .PAUSE_REQ_OUT);

/* File: tb/tmc_scan_target.sv */
// One-bit bypass chain standing for the scan targets.
`timescale 1ns/1ps
module tmc_scan_target (
  input wire logic tck_in,
  input wire logic tdi_in,
  input wire logic trst_n_in,
  input wire logic oe_in,
  output logic tdo_out
);
  logic tck;
  logic cap = 1'b1;
  logic q = 1'b1;
  // A released clock is pulled low, so the chain stands still.
  assign tck = oe_in & tck_in;
  // Released data reads as the pull-up level.
  always @(posedge tck) cap <= oe_in ? tdi_in : 1'b1;
  // Data leaves on the falling clock edge.
  always @(negedge tck) q <= cap;
  // Held in reset the target floats its output, which pulls high.
  assign tdo_out = (oe_in && !trst_n_in) ? 1'b1 : q;
endmodule : tmc_scan_target

/* File: tb/tmc_tb_top.sv */
// Testbench for the TAP master configuration block.
`timescale 1ns/1ps
module tmc_tb_top;
  logic CLK_IN = 0, RST_IN = 0, REFERENCE_CLOCK_IN = 0, STRB_N_IN = 1;
  logic TDO_EMPTY_IN = 0;
  logic RW_IN = 1, SOFT_RESET_IN = 0, CMD_BUSY_IN = 0, TDI_IN, TCK_NEED_IN = 0;
  logic HW_OUTPUT_ENABLE_PIN_N_IN = 0, SCAN_ACTIVE_IN = 0, TDI_FULL_IN = 0;
  logic SHIFT_STATE_IN = 0, GEN_TMS_IN = 0, TDO_SERIAL_IN = 0;
  logic DISC_NTRST_IN = 1, DISC_TMS_IN = 0, DISC_TDO_IN = 0;
  logic [2:0] ADDR_IN = 3'h0;
  logic [7:0] DATA_IN = 8'h00, DATA_OUT, q;
  logic DATA_OE_OUT, RDY_OUT, TCK_OUT, TMS_OUT, TDO_OUT, TRST_N_OUT, oe;
  logic TAP_OE_OUT, TDI_BIT_OUT, TDI_BIT_VALID_OUT, PAUSE_REQ_OUT, rdy, v;
  int n_mismatch = 0, num_checks = 0, n, k, d;
  int mdl [2] = '{0, 128};
  int ex [4] = '{1, 3, 4, 7};
  // Host clock and an unrelated link clock.
  always #2.5 CLK_IN = ~CLK_IN;
  always #24 REFERENCE_CLOCK_IN = ~REFERENCE_CLOCK_IN;
  tmc_top u_dut (.CLK_IN, .RST_IN, .REFERENCE_CLOCK_IN, .STRB_N_IN, .RW_IN,
    .ADDR_IN, .DATA_IN, .DATA_OUT, .DATA_OE_OUT, .RDY_OUT, .SOFT_RESET_IN,
    .CMD_BUSY_IN, .TDI_IN, .HW_OUTPUT_ENABLE_PIN_N_IN, .SCAN_ACTIVE_IN,
    .TDI_FULL_IN, .TDO_EMPTY_IN, .TCK_NEED_IN, .SHIFT_STATE_IN,
    .GEN_TMS_IN, .TDO_SERIAL_IN, .CMD_TRST_N_IN(1'b1), .DISC_NTRST_IN,
    .DISC_TMS_IN, .DISC_TDO_IN, .TCK_OUT, .TMS_OUT, .TDO_OUT, .TRST_N_OUT,
    .TAP_OE_OUT, .TDI_BIT_OUT, .TDI_BIT_VALID_OUT, .PAUSE_REQ_OUT);
  tmc_scan_target u_tgt (.tck_in(TCK_OUT), .tdi_in(TDO_OUT),
    .trst_n_in(TRST_N_OUT), .oe_in(TAP_OE_OUT), .tdo_out(TDI_IN));
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  task chk(input string s, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // One host access; the model takes writes that are not held off.
  task acc(input logic r, input logic [2:0] a, input logic [7:0] dv);
    @(posedge CLK_IN);
    STRB_N_IN <= 1'b0;
    RW_IN <= r;
    ADDR_IN <= a;
    DATA_IN <= dv;
    repeat (8) @(posedge CLK_IN);
    q = DATA_OUT;
    oe = DATA_OE_OUT;
    rdy = RDY_OUT;
    STRB_N_IN <= 1'b1;
    repeat (120) @(posedge CLK_IN);
    if (!r && a < 3'h2 && !CMD_BUSY_IN) mdl[a] = dv & (a ? 8'hEF : 8'h3F);
  endtask : acc
  task rdc(input logic [2:0] a);
    acc(1'b1, a, 8'h00);
    chk("register read", 8'(mdl[a]), q);
    chk("read drive and ready", 8'h03, {6'h0, oe, rdy});
  endtask : rdc
  task lk(input int c);
    repeat (c) @(posedge REFERENCE_CLOCK_IN);
  endtask : lk
  // Waits for the next TCK rise; n is the link cycles it took.
  task rise;
    logic p;
    n = 0;
    p = TCK_OUT;
    forever begin
      @(posedge REFERENCE_CLOCK_IN);
      n++;
      if ((TCK_OUT === 1'b1 && p === 1'b0) || n > 299) break;
      p = TCK_OUT;
    end
    v = TDI_BIT_VALID_OUT;
  endtask : rise
  // Notes in v whether TCK went high in a 40-cycle window.
  task quiet;
    lk(20);
    v = 1'b0;
    repeat (40) begin
      @(posedge REFERENCE_CLOCK_IN);
      v = v | TCK_OUT;
    end
  endtask : quiet
  task oe_chk(input logic e);
    lk(10);
    chk("output enable", {7'h0, e}, {7'h0, TAP_OE_OUT});
  endtask : oe_chk
  // Watchdog against a hang.
  initial begin
    repeat (80000) @(posedge CLK_IN);
    n_mismatch++;
    finish_test;
  end
  // Main sequence.
  initial begin
    void'($urandom(32'hF8EA95F1));
    // A real edge on reset clears both clock domains at once.
    RST_IN <= 1'b1;
    repeat (5) @(posedge CLK_IN);
    RST_IN <= 1'b0;
    repeat (10) @(posedge CLK_IN);
    rdc(3'h0);
    rdc(3'h1);
    d = $urandom % 3;
    acc(1'b0, 3'h0, 8'hC0 | 8'(d << 3) | 8'(d));
    rdc(3'h0);
    acc(1'b0, 3'h1, 8'($urandom));
    rdc(3'h1);
    CMD_BUSY_IN <= 1'b1;
    acc(1'b0, 3'h0, 8'h12);
    chk("ready", 8'h00, {7'h0, rdy});
    CMD_BUSY_IN <= 1'b0;
    rdc(3'h0);
    acc(1'b1, 3'h5, 8'h00);
    chk("unmapped drive", 8'h00, {7'h0, oe});
    SOFT_RESET_IN <= 1'b1;
    @(posedge CLK_IN);
    SOFT_RESET_IN <= 1'b0;
    mdl = '{0, 128};
    rdc(3'h0);
    rdc(3'h1);
    rise;
    rise;
    chk("reset period", 8'h10, 8'(n));
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 3'h1, 8'(ex[i] << 5));
      rise;
      rise;
      chk("tck period", 8'(1 << ex[i]), 8'(n));
    end
    acc(1'b0, 3'h1, 8'h80);
    // With loopback 01 and 10 the chosen source differs from the others; all three should give 0.
    for (int l = 0; l < 3; l++) begin
      acc(1'b0, 3'h0, 8'(l << 3));
      lk(1);
      GEN_TMS_IN <= (l != 1);
      TDO_SERIAL_IN <= (l == 1);
      SCAN_ACTIVE_IN <= 1'b1;
      rise;
      SHIFT_STATE_IN <= 1'b1;
      rise;
      rise;
      chk("loopback", 8'h05, {5'h0, v, TDI_BIT_OUT,
        (l == 0) | (TMS_OUT & TDO_OUT)});
      SHIFT_STATE_IN <= 1'b0;
    end
    d = 1 + $urandom % 15;
    acc(1'b0, 3'h1, 8'h80 | 8'(d));
    acc(1'b0, 3'h0, 8'h00);
    rise;
    SHIFT_STATE_IN <= 1'b1;
    k = 0;
    do begin
      rise;
      k++;
    end while (!v && k < 20);
    chk("retiming delay", 8'(d + 1), 8'(k));
    SHIFT_STATE_IN <= 1'b0;
    acc(1'b0, 3'h0, 8'(tmc_pkg::MODE_GATED));
    lk(1);
    TDI_FULL_IN <= 1'b1;
    TCK_NEED_IN <= 1'b1;
    quiet;
    chk("gated stall", 8'h00, {6'h0, v, PAUSE_REQ_OUT});
    TDI_FULL_IN <= 1'b0;
    TCK_NEED_IN <= 1'b0;
    quiet;
    chk("gated idle", 8'h00, {7'h0, v});
    TCK_NEED_IN <= 1'b1;
    rise;
    rise;
    chk("gated period", 8'h10, 8'(n));
    acc(1'b0, 3'h0, 8'(tmc_pkg::MODE_FREE));
    lk(1);
    TDO_EMPTY_IN <= 1'b1;
    TCK_NEED_IN <= 1'b0;
    rise;
    rise;
    chk("free stall", 8'h90, {PAUSE_REQ_OUT, 7'(n)});
    TDO_EMPTY_IN <= 1'b0;
    SCAN_ACTIVE_IN <= 1'b0;
    acc(1'b0, 3'h0, 8'(tmc_pkg::MODE_DISCRETE));
    for (int i = 0; i < 4; i++) begin
      lk(1);
      d = $urandom;
      {DISC_NTRST_IN, DISC_TMS_IN, DISC_TDO_IN} <= 3'(d);
      lk(3);
      chk("discrete", 8'(d & 7),
        {4'h0, TCK_OUT, TRST_N_OUT, TMS_OUT, TDO_OUT});
    end
    acc(1'b0, 3'h0, 8'h20);
    oe_chk(1'b0);
    acc(1'b0, 3'h0, 8'h00);
    oe_chk(1'b1);
    HW_OUTPUT_ENABLE_PIN_N_IN <= 1'b1;
    oe_chk(1'b0);
    HW_OUTPUT_ENABLE_PIN_N_IN <= 1'b0;
    oe_chk(1'b1);
    // A second hardware reset in mid-run restores both registers.
    RST_IN <= 1'b1;
    lk(3);
    RST_IN <= 1'b0;
    mdl = '{0, 128};
    repeat (10) @(posedge CLK_IN);
    rdc(3'h0);
    rdc(3'h1);
    rise;
    rise;
    chk("hard reset period", 8'h10, 8'(n));
    finish_test;
  end
endmodule : tmc_tb_top
